// [verilog/priority_interrupt_controller.sv]
`timescale 1ns/1ps

module priority_interrupt_controller
(
  // Clock and reset.
  input wire logic i_sys_clk,
  input wire logic i_rst,
  // Register bus from the processor.
  input wire intc_pkg::io_req_t i_io,
  output logic [7:0] o_io_rdata,
  // Interrupt events from the peripherals, one-cycle pulses.
  input wire logic [14:0] i_src_event,
  // GPIO pin events with their enables and edge types.
  input wire logic [7:0] i_gpio_pin_event,
  input wire logic [7:0] i_gpio_pin_en,
  input wire logic [15:0] i_gpio_edge_type,
  // Processor flag register access.
  input wire logic i_flag_wr,
  input wire logic [7:0] i_flag_wdata,
  input wire logic i_return_from_interrupt,
  input wire logic [7:0] i_return_from_interrupt_flags,
  output logic [7:0] o_flags,
  // Acknowledge handshake with the core.
  input wire logic i_ack_take,
  input wire logic [15:0] i_program_counter_register,
  output logic o_irq,
  output logic o_ack_busy,
  output intc_pkg::stack_push_t o_stack,
  output logic o_pc_load,
  output logic [15:0] o_pc_vector
);

  // All checks run on the system clock and rest while reset is high.
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);

  ////////////////////////////////////////////////////////////////
  // Helpers.
  // Priority number of the lowest set bit, zero if none.
  function automatic logic [3:0] pick(input logic [14:0] r);
    pick = 4'h0;
    for (int i = intc_pkg::NUM_SRC - 1; i >= 0; i--)
    begin
      if (r[i])
      begin
        pick = 4'(i + 1);
      end
    end
  endfunction

  // Table address of a priority number, four bytes per entry.
  function automatic logic [15:0] vec_addr(input logic [3:0] p);
    vec_addr = {10'h000, p, 2'b00};
  endfunction

  ////////////////////////////////////////////////////////////////
  // State.
  // Pending flags, one per source.
  logic [14:0] pend_q, pend_d;
  // General and block mask registers.
  logic [7:0] gen_q, gen_d, blk_q, blk_d;
  // Flag register holding the global enable.
  logic [7:0] flags_q, flags_d;
  // Registered read data.
  logic [7:0] rdata_q, rdata_d;
  // Request line to the core.
  logic irq_q, irq_d;
  // Priority number latched at acknowledge.
  logic [3:0] sel_q, sel_d;
  // Program counter saved at acknowledge.
  logic [15:0] pcsave_q, pcsave_d;
  // Stack push, PC load and vector outputs.
  intc_pkg::stack_push_t push_q, push_d;
  logic pcl_q, pcl_d;
  logic [15:0] vec_q, vec_d;
  // Combined events, enable map, selection and its table address.
  logic [14:0] ev, en, clr;
  logic gpio_hit, start, ie;
  logic [3:0] take_prio, top_prio;
  logic [15:0] top_vec;
  // Sequencer state.
  logic [3:0] cnt;
  logic busy;

  ////////////////////////////////////////////////////////////////
  // Acknowledge sequencer.
  intc_ack_seq u_seq
  (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_start(start),
    .o_cnt(cnt),
    .o_busy(busy)
  );

  ////////////////////////////////////////////////////////////////
  // Event gathering, enable map and priority selection.
  always_comb
  begin
    // A pin counts only with its enable set and a nonzero edge type.
    gpio_hit = 1'b0;
    for (int p = 0; p < intc_pkg::GPIO_PINS; p++)
    begin
      if (i_gpio_pin_event[p] && i_gpio_pin_en[p] && (i_gpio_edge_type[2*p +: 2] != 2'b00))
      begin
        gpio_hit = 1'b1;
      end
    end
    ev = i_src_event;
    ev[intc_pkg::SRC_GPIO] = gpio_hit;
    // Map mask bits onto sources in priority order.
    en[intc_pkg::SRC_SUPPLY] = gen_q[intc_pkg::GEN_SUPPLY];
    en[intc_pkg::SRC_BLK0 +: 8] = blk_q;
    en[intc_pkg::SRC_COL0 +: 4] = gen_q[intc_pkg::GEN_COL0 +: 4];
    en[intc_pkg::SRC_GPIO] = gen_q[intc_pkg::GEN_GPIO];
    en[intc_pkg::SRC_SLEEP] = gen_q[intc_pkg::GEN_SLEEP];
    ie = flags_q[intc_pkg::IE_BIT];
    // Lowest number wins among enabled pending sources.
    take_prio = pick(pend_q & en);
    top_prio = take_prio;
    top_vec = vec_addr(top_prio);
    start = i_ack_take && !busy;
  end

  ////////////////////////////////////////////////////////////////
  // Pending flags: set wins over every clear.
  always_comb
  begin
    clr = 15'h0000;
    if (i_io.wr && i_io.addr == intc_pkg::ADDR_VECTOR)
    begin
      // Any vector write drops every pending flag.
      clr = '1;
    end
    else if (start && take_prio != 4'h0)
    begin
      // Only the source being serviced is dropped.
      clr[take_prio - 4'h1] = 1'b1;
    end
    pend_d = (pend_q & ~clr) | ev;
  end

  // Pending register.
  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      pend_q <= 15'h0000;
    end
    else
    begin
      pend_q <= pend_d;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Mask registers and read data.
  always_comb
  begin
    gen_d = gen_q;
    blk_d = blk_q;
    rdata_d = rdata_q;
    if (i_io.wr && i_io.addr == intc_pkg::ADDR_GEN_MASK)
    begin
      gen_d = i_io.wdata;
    end
    if (i_io.wr && i_io.addr == intc_pkg::ADDR_BLK_MASK)
    begin
      blk_d = i_io.wdata;
    end
    if (i_io.rd)
    begin
      case (i_io.addr)
        intc_pkg::ADDR_GEN_MASK: rdata_d = gen_q;
        intc_pkg::ADDR_BLK_MASK: rdata_d = blk_q;
        // Vector of the top enabled pending source.
        intc_pkg::ADDR_VECTOR: rdata_d = top_vec[7:0];
        default: rdata_d = 8'h00;
      endcase
    end
  end

  // Mask and read data registers, masks cleared by reset.
  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      gen_q <= intc_pkg::MASK_RST;
      blk_q <= intc_pkg::MASK_RST;
      rdata_q <= 8'h00;
    end
    else
    begin
      gen_q <= gen_d;
      blk_q <= blk_d;
      rdata_q <= rdata_d;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Flag register: the call clear beats return and software.
  always_comb
  begin
    flags_d = flags_q;
    if (busy && cnt == intc_pkg::STEP_PUSH_FLAGS)
    begin
      // Stacked this cycle, so clearing now keeps the old copy.
      flags_d = 8'h00;
    end
    else if (i_return_from_interrupt)
    begin
      flags_d = i_return_from_interrupt_flags;
    end
    else if (i_flag_wr)
    begin
      // Setting the enable inside a handler re-arms requests.
      flags_d = i_flag_wdata;
    end
  end

  // Flag register, global enable off after reset.
  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      flags_q <= intc_pkg::FLAGS_RST;
    end
    else
    begin
      flags_q <= flags_d;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Request line and acknowledge call.
  always_comb
  begin
    // No new request while a call is being made.
    irq_d = (|(pend_q & en)) && ie && !busy;
    sel_d = sel_q;
    pcsave_d = pcsave_q;
    push_d = '0;
    pcl_d = 1'b0;
    vec_d = vec_q;
    if (start)
    begin
      // Zero here means the request vanished; vector is 0000h.
      sel_d = take_prio;
      pcsave_d = i_program_counter_register;
    end
    if (busy)
    begin
      case (cnt)
        intc_pkg::STEP_PUSH_PC_HI: push_d = '{1'b1, pcsave_q[15:8]};
        intc_pkg::STEP_PUSH_PC_LO: push_d = '{1'b1, pcsave_q[7:0]};
        intc_pkg::STEP_PUSH_FLAGS: push_d = '{1'b1, flags_q};
        intc_pkg::ACK_CALL_CYCLES:
        begin
          // Last step of the call jumps into the table.
          pcl_d = 1'b1;
          vec_d = vec_addr(sel_q);
        end
        default: push_d = '0;
      endcase
    end
  end

  // Request and call registers.
  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      irq_q <= 1'b0;
      sel_q <= 4'h0;
      pcsave_q <= 16'h0000;
      push_q <= '0;
      pcl_q <= 1'b0;
      vec_q <= 16'h0000;
    end
    else
    begin
      irq_q <= irq_d;
      sel_q <= sel_d;
      pcsave_q <= pcsave_d;
      push_q <= push_d;
      pcl_q <= pcl_d;
      vec_q <= vec_d;
    end
  end

  // Outputs come straight from registers.
  assign o_io_rdata = rdata_q;
  assign o_flags = flags_q;
  assign o_irq = irq_q;
  assign o_ack_busy = busy;
  assign o_stack = push_q;
  assign o_pc_load = pcl_q;
  assign o_pc_vector = vec_q;

  ////////////////////////////////////////////////////////////////
  // Checks.
  property p_pend_set;
    (ev != 15'h0000) |=> ((pend_q & $past(ev)) == $past(ev));
  endproperty
  a_pend_set: assert property (p_pend_set) else $error("event lost");
  property p_vec_clr;
    (i_io.wr && i_io.addr == intc_pkg::ADDR_VECTOR && ev == 15'h0000)
      |=> (pend_q == 15'h0000);
  endproperty
  a_vec_clr: assert property (p_vec_clr) else $error("vector write kept pending");
  property p_irq_gate;
    $rose(o_irq) |-> $past(ie) && ($past(pend_q & en) != 15'h0000);
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("request without enable");
  property p_call_len;
    start |-> ##13 busy ##1 (o_pc_load && !busy) ##1 !o_pc_load;
  endproperty
  a_call_len: assert property (p_call_len) else $error("call length wrong");
  property p_push_hi;
    start |-> ##2 (o_stack.valid && o_stack.data == $past(i_program_counter_register[15:8], 2))
      ##1 (o_stack.valid && o_stack.data == $past(i_program_counter_register[7:0], 3));
  endproperty
  a_push_hi: assert property (p_push_hi) else $error("PC push wrong");
  property p_flag_clr;
    (busy && cnt == intc_pkg::STEP_PUSH_FLAGS)
      |=> (flags_q == 8'h00) && o_stack.data == $past(flags_q);
  endproperty
  a_flag_clr: assert property (p_flag_clr) else $error("flags not stacked and cleared");
  property p_return_from_interrupt;
    (i_return_from_interrupt && !busy) |=> (flags_q == $past(i_return_from_interrupt_flags));
  endproperty
  a_return_from_interrupt: assert property (p_return_from_interrupt) else $error("flags not restored");
  property p_vector;
    start |-> ##14 (o_pc_vector == vec_addr($past(take_prio, 14)));
  endproperty
  a_vector: assert property (p_vector) else $error("wrong vector loaded");
  property p_one_clear;
    (start && take_prio != 4'h0 && ev == 15'h0000 && !i_io.wr)
      |=> (pend_q == ($past(pend_q) & ~(15'h0001 << ($past(take_prio) - 4'h1))));
  endproperty
  a_one_clear: assert property (p_one_clear) else $error("ack clear wrong");
  property p_rd_vec;
    (i_io.rd && i_io.addr == intc_pkg::ADDR_VECTOR)
      |=> (o_io_rdata == {2'b00, $past(top_prio), 2'b00});
  endproperty
  a_rd_vec: assert property (p_rd_vec) else $error("vector read wrong");

endmodule

// [verilog/intc_pkg.sv]
package intc_pkg;

  // Register addresses on the processor I/O space.
  localparam logic [7:0] ADDR_GEN_MASK = 8'hE0;
  localparam logic [7:0] ADDR_BLK_MASK = 8'hE1;
  localparam logic [7:0] ADDR_VECTOR = 8'hE2;

  // Reset values of the stored registers.
  localparam logic [7:0] MASK_RST = 8'h00;
  localparam logic [7:0] FLAGS_RST = 8'h00;

  // Number of interrupt sources.
  localparam int NUM_SRC = 15;

  // Global enable bit inside the flag register.
  localparam int IE_BIT = 0;

  // Bit positions inside the general mask register.
  localparam int GEN_SUPPLY = 0;
  localparam int GEN_COL0 = 1;
  localparam int GEN_GPIO = 5;
  localparam int GEN_SLEEP = 6;

  // Source index of each group; priority number is index plus one.
  localparam int SRC_SUPPLY = 0;
  localparam int SRC_BLK0 = 1;
  localparam int SRC_COL0 = 9;
  localparam int SRC_GPIO = 13;
  localparam int SRC_SLEEP = 14;

  // Number of GPIO pins feeding the shared group source.
  localparam int GPIO_PINS = 8;

  // Length of the automatic call and its steps, in processor cycles.
  localparam logic [3:0] ACK_CALL_CYCLES = 4'hD;
  localparam logic [3:0] STEP_PUSH_PC_HI = 4'h1;
  localparam logic [3:0] STEP_PUSH_PC_LO = 4'h2;
  localparam logic [3:0] STEP_PUSH_FLAGS = 4'h3;

  // Register bus request from the processor.
  typedef struct packed {
    logic [7:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } io_req_t;

  // One byte pushed onto the program stack.
  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } stack_push_t;

endpackage

// [verilog/intc_ack_seq.sv]
`timescale 1ns/1ps

// Counts the steps of the automatic call made on acknowledge.
module intc_ack_seq
(
  // Clock and reset.
  input wire logic i_sys_clk,
  input wire logic i_rst,
  // Start of an acknowledge.
  input wire logic i_start,
  // Step count and busy level.
  output logic [3:0] o_cnt,
  output logic o_busy
);

  // Current step, zero when idle.
  logic [3:0] cnt_q;
  logic [3:0] cnt_d;
  // Busy flag, high for the whole call.
  logic busy_q;
  logic busy_d;

  ////////////////////////////////////////////////////////////////
  // Next step: start at one, run to the last step, then idle.
  always_comb
  begin
    cnt_d = cnt_q;
    busy_d = busy_q;
    if (i_start && !busy_q)
    begin
      cnt_d = 4'h1;
      busy_d = 1'b1;
    end
    else if (busy_q)
    begin
      // The last step ends the call.
      if (cnt_q == intc_pkg::ACK_CALL_CYCLES)
      begin
        cnt_d = 4'h0;
        busy_d = 1'b0;
      end
      else
      begin
        cnt_d = cnt_q + 4'h1;
      end
    end
  end

  // Registers of the sequencer.
  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      cnt_q <= 4'h0;
      busy_q <= 1'b0;
    end
    else
    begin
      cnt_q <= cnt_d;
      busy_q <= busy_d;
    end
  end

  assign o_cnt = cnt_q;
  assign o_busy = busy_q;

endmodule

// [tb/core_model.sv]
`timescale 1ns/1ps

// Stand-in for the processor core: takes requests and logs each call.
module core_model
(
  // Clock and reset.
  input wire logic i_sys_clk,
  input wire logic i_rst,
  // Take control from the bench.
  input wire logic i_auto,
  input wire logic i_kick,
  // Controller side.
  input wire logic i_irq,
  input wire logic i_busy,
  input wire intc_pkg::stack_push_t i_stack,
  output logic o_take,
  output logic [15:0] o_pc,
  // Log of the last call.
  output logic [23:0] o_stk,
  output logic [7:0] o_busy_n
);
  // A fixed program counter makes the stacked bytes easy to predict.
  assign o_pc = 16'hA5C3;

  // A take lasts one cycle and is only made while the controller is idle.
  always @(posedge i_sys_clk)
  begin
    o_take <= !i_rst && !o_take && !i_busy && (i_kick || (i_auto && i_irq));
    if (i_stack.valid)
    begin
      o_stk <= {o_stk[15:0], i_stack.data};
    end
    o_busy_n <= o_take ? 8'h00 : o_busy_n + {7'h00, i_busy};
  end
endmodule

// [tb/priority_interrupt_controller_tb_top.sv]
`timescale 1ns/1ps

// Self-checking bench: a table of single sources, then hand-written cases.
module priority_interrupt_controller_tb_top;
  typedef struct packed
  {
    logic [14:0] ev;
    logic [7:0] gm;
    logic [7:0] bm;
    logic [15:0] v;
  } row_t;
  logic i_sys_clk;
  logic i_rst;
  intc_pkg::io_req_t i_io;
  logic [7:0] o_io_rdata;
  logic [14:0] i_src_event;
  logic [7:0] i_gpio_pin_event;
  logic [7:0] i_gpio_pin_en;
  logic [15:0] i_gpio_edge_type;
  logic i_flag_wr;
  logic [7:0] i_flag_wdata;
  logic i_return_from_interrupt;
  logic [7:0] o_flags;
  logic i_ack_take;
  logic [15:0] i_program_counter_register;
  logic o_irq;
  logic o_ack_busy;
  intc_pkg::stack_push_t o_stack;
  logic o_pc_load;
  logic [15:0] o_pc_vector;
  logic auto_en;
  logic kick;
  logic [23:0] stk;
  logic [7:0] busy_n;
  int error_cnt;
  int n_checks;
  // Each source except the GPIO group alone, with only its own mask bit set.
  row_t rows [14] = '{
    '{15'h0001, 8'h01, 8'h00, 16'h0004}, '{15'h0002, 8'h00, 8'h01, 16'h0008},
    '{15'h0004, 8'h00, 8'h02, 16'h000C}, '{15'h0008, 8'h00, 8'h04, 16'h0010},
    '{15'h0010, 8'h00, 8'h08, 16'h0014}, '{15'h0020, 8'h00, 8'h10, 16'h0018},
    '{15'h0040, 8'h00, 8'h20, 16'h001C}, '{15'h0080, 8'h00, 8'h40, 16'h0020},
    '{15'h0100, 8'h00, 8'h80, 16'h0024}, '{15'h0200, 8'h02, 8'h00, 16'h0028},
    '{15'h0400, 8'h04, 8'h00, 16'h002C}, '{15'h0800, 8'h08, 8'h00, 16'h0030},
    '{15'h1000, 8'h10, 8'h00, 16'h0034}, '{15'h4000, 8'h40, 8'h00, 16'h003C}};

  priority_interrupt_controller uut
  (
    .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_io(i_io), .o_io_rdata(o_io_rdata),
    .i_src_event(i_src_event), .i_gpio_pin_event(i_gpio_pin_event),
    .i_gpio_pin_en(i_gpio_pin_en), .i_gpio_edge_type(i_gpio_edge_type),
    .i_flag_wr(i_flag_wr), .i_flag_wdata(i_flag_wdata), .i_return_from_interrupt(i_return_from_interrupt),
    .i_return_from_interrupt_flags(i_flag_wdata), .o_flags(o_flags), .i_ack_take(i_ack_take),
    .i_program_counter_register(i_program_counter_register), .o_irq(o_irq), .o_ack_busy(o_ack_busy), .o_stack(o_stack),
    .o_pc_load(o_pc_load), .o_pc_vector(o_pc_vector)
  );

  core_model core
  (
    .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_auto(auto_en), .i_kick(kick),
    .i_irq(o_irq), .i_busy(o_ack_busy), .i_stack(o_stack), .o_take(i_ack_take),
    .o_pc(i_program_counter_register), .o_stk(stk), .o_busy_n(busy_n)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Clock at 200 MHz.
  initial
  begin
    i_sys_clk = 1'b0;
    forever #2.5 i_sys_clk = !i_sys_clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Compares a value and counts the outcome.
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("unexpected at %0t: seen %0h, expected %0h", $time, seen, exp);
    end
  endtask

  // One register write, then one register read with its check.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_sys_clk);
    i_io <= '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
    @(posedge i_sys_clk);
    i_io.wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge i_sys_clk);
    i_io <= '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
    @(posedge i_sys_clk);
    i_io.rd <= 1'b0;
    @(negedge i_sys_clk);
    chk({8'h00, o_io_rdata}, {8'h00, e});
  endtask

  // One-cycle event pulses on sources and pins.
  task automatic ev(input logic [14:0] s, input logic [7:0] p);
    @(posedge i_sys_clk);
    i_src_event <= s;
    i_gpio_pin_event <= p;
    @(posedge i_sys_clk);
    i_src_event <= '0;
    i_gpio_pin_event <= '0;
  endtask

  // Flag write (r low) or return from interrupt (r high).
  task automatic flg(input logic [7:0] f, input logic r);
    @(posedge i_sys_clk);
    i_flag_wdata <= f;
    i_flag_wr <= !r;
    i_return_from_interrupt <= r;
    @(posedge i_sys_clk);
    i_flag_wr <= 1'b0;
    i_return_from_interrupt <= 1'b0;
    @(negedge i_sys_clk);
    chk({8'h00, o_flags}, {8'h00, f});
  endtask

  task automatic irq_is(input int n, input logic e);
    repeat (n) @(posedge i_sys_clk);
    @(negedge i_sys_clk);
    chk({15'h0000, o_irq}, {15'h0000, e});
  endtask

  // Lets the core take one interrupt and checks the whole call.
  task automatic take(input logic [15:0] v, input logic k);
    int t;
    @(posedge i_sys_clk);
    auto_en <= !k;
    kick <= k;
    @(posedge i_sys_clk);
    kick <= 1'b0;
    t = 0;
    while (o_pc_load !== 1'b1 && t < 40)
    begin
      @(negedge i_sys_clk);
      t++;
    end
    chk({15'h0000, o_pc_load}, 16'h0001);
    chk(o_pc_vector, v);
    chk({8'h00, o_flags}, 16'h0000);
    chk(stk[23:8], 16'hA5C3);
    chk({8'h00, stk[7:0]}, 16'h0001);
    chk({8'h00, busy_n}, 16'h000D);
    @(posedge i_sys_clk);
    auto_en <= 1'b0;
  endtask

  task automatic stop_test;
    $display("checks %0d, mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
    begin
      $display("Result: passed");
    end
    else
    begin
      $display("Result: failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Watchdog well beyond the expected run.
  initial
  begin
    #60000;
    error_cnt++;
    stop_test();
  end

  // Main sequence.
  initial
  begin
    i_rst = 1'b1;
    i_io = '0;
    i_src_event = '0;
    i_gpio_pin_event = '0;
    i_gpio_pin_en = '0;
    i_gpio_edge_type = '0;
    i_flag_wr = 1'b0;
    i_flag_wdata = '0;
    i_return_from_interrupt = 1'b0;
    auto_en = 1'b0;
    kick = 1'b0;
    error_cnt = 0;
    n_checks = 0;
    repeat (4) @(posedge i_sys_clk);
    i_rst <= 1'b0;
    // Masks and enable are set, then a reset in mid-run must clear them.
    wr(intc_pkg::ADDR_GEN_MASK, 8'hFF);
    wr(intc_pkg::ADDR_BLK_MASK, 8'hFF);
    rd(intc_pkg::ADDR_GEN_MASK, 8'hFF);
    flg(8'h01, 1'b0);
    @(posedge i_sys_clk);
    i_rst <= 1'b1;
    repeat (4) @(posedge i_sys_clk);
    i_rst <= 1'b0;
    rd(intc_pkg::ADDR_GEN_MASK, 8'h00);
    rd(intc_pkg::ADDR_BLK_MASK, 8'h00);
    chk({8'h00, o_flags}, 16'h0000);
    $display("test reset done");
    // Analog column sources are taken as already selected by software.
    foreach (rows[i])
    begin
      wr(intc_pkg::ADDR_GEN_MASK, rows[i].gm);
      wr(intc_pkg::ADDR_BLK_MASK, rows[i].bm);
      flg(8'h01, 1'b0);
      ev(rows[i].ev, 8'h00);
      rd(intc_pkg::ADDR_VECTOR, rows[i].v[7:0]);
      take(rows[i].v, 1'b0);
      flg(8'h01, 1'b1);
    end
    $display("test table done");
    // Masked or disabled requests stay quiet; a vector write drops pending.
    wr(intc_pkg::ADDR_GEN_MASK, 8'h00);
    wr(intc_pkg::ADDR_BLK_MASK, 8'h00);
    ev(15'h0001, 8'h00);
    irq_is(3, 1'b0);
    rd(intc_pkg::ADDR_VECTOR, 8'h00);
    wr(intc_pkg::ADDR_GEN_MASK, 8'h01);
    irq_is(2, 1'b1);
    flg(8'h00, 1'b0);
    irq_is(2, 1'b0);
    wr(intc_pkg::ADDR_VECTOR, 8'h00);
    flg(8'h01, 1'b0);
    irq_is(2, 1'b0);
    $display("test masking done");
    // Two pending at once: lower number first, then the other by nesting.
    wr(intc_pkg::ADDR_BLK_MASK, 8'h0A);
    ev(15'h0014, 8'h00);
    take(16'h000C, 1'b0);
    flg(8'h01, 1'b0);
    take(16'h0014, 1'b0);
    flg(8'h01, 1'b1);
    $display("test priority done");
    // A pin counts only with its enable and a non-zero edge type.
    wr(intc_pkg::ADDR_BLK_MASK, 8'h00);
    wr(intc_pkg::ADDR_GEN_MASK, 8'h20);
    i_gpio_pin_en <= 8'h08;
    i_gpio_edge_type <= 16'h0010;
    ev(15'h0000, 8'h04);
    irq_is(3, 1'b0);
    i_gpio_pin_en <= 8'h04;
    i_gpio_edge_type <= 16'h0000;
    ev(15'h0000, 8'h04);
    irq_is(3, 1'b0);
    i_gpio_edge_type <= 16'h0010;
    ev(15'h0000, 8'h04);
    take(16'h0038, 1'b0);
    flg(8'h01, 1'b1);
    $display("test gpio done");
    // The only pending source is masked just before the take.
    wr(intc_pkg::ADDR_GEN_MASK, 8'h01);
    ev(15'h0001, 8'h00);
    wr(intc_pkg::ADDR_GEN_MASK, 8'h00);
    take(16'h0000, 1'b1);
    $display("test vanished done");
    stop_test();
  end
endmodule
